// >>> verilog/pcr_top.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Nine-bit multiplier split over two registers
// - Five-bit reference divider, host writable, resets zero
// - Select bit picks table or direct programming
// - Direct frequency is reference times (N+4)/M
// - Watchdog expiry clears select, picks fallback or latched default code
// - Decode ratio code into three divide ratios
// - Four-bit spread rise count, resets to one
// - Four-bit spread fall count, resets all ones
// - Read-only part identifier at register eleven
// - Expiry with reload copies fallback code
// - Two-wire bus at address 0xd2
module pcr_top (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Two-wire serial bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Watchdog and frequency straps, same clock domain
  input wire logic watchdog_expire,
  input wire logic safe_freq_enable,
  input wire logic [4:0] fallback_frequency_code,
  input wire logic [4:0] latched_default_code,
  // Frequency programming outputs
  output logic direct_program_select,
  output logic [4:0] frequency_select_code,
  output logic [9:0] vco_numerator,
  output logic [4:0] vco_denominator,
  output logic [3:0] spread_rise_count,
  output logic [3:0] spread_fall_count,
  // Decoded output divide ratios
  output logic [3:0] cpu_ratio,
  output logic [3:0] v66_ratio,
  output logic [3:0] pci_ratio
);
  import pcr_pkg::*;

  // Pin synchronisers plus one history stage for edge detection
  logic [2:0] scl_sync_q;
  logic [2:0] sda_sync_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  // Serial engine state
  pcr_state_e state_q, state_d;
  logic [3:0] cnt_q, cnt_d;       // Bits moved in the current byte
  logic [7:0] shift_q, shift_d;   // Received byte
  logic [7:0] tx_q, tx_d;         // Byte being sent, msb on the wire
  logic [7:0] ptr_q, ptr_d;       // Register pointer
  logic rw_q, rw_d;               // Read direction from address byte
  logic block_q, block_d;         // Block mode selected by command
  logic first_q, first_d;         // Next byte is the block count
  logic nack_q, nack_d;           // Master declined further bytes
  logic oe_q, oe_d;
  logic sda_o_q;
  logic wr_en;                    // One-cycle register write strobe
  logic [7:0] rd_byte;

  // Register storage
  logic [8:0] mult_q, mult_d;
  logic [4:0] refdiv_q, refdiv_d;
  logic fact_hi_q, fact_hi_d, fact_lo_q, fact_lo_d;
  logic [3:0] rise_q, rise_d, fall_q, fall_d;
  logic direct_q, direct_d;
  logic [2:0] ratio_q, ratio_d, skew_q, skew_d;
  logic [4:0] freq_code_q, freq_code_d;
  logic [9:0] num_q, num_d;
  logic [11:0] div_q, div_d;

  // Edges seen on the second and third synchroniser stages only
  assign scl_rise = scl_sync_q[1] & ~scl_sync_q[2];
  assign scl_fall = ~scl_sync_q[1] & scl_sync_q[2];
  assign bus_start = scl_sync_q[1] & scl_sync_q[2] & ~sda_sync_q[1] & sda_sync_q[2];
  assign bus_stop = scl_sync_q[1] & scl_sync_q[2] & sda_sync_q[1] & ~sda_sync_q[2];

  // Synchronisers idle high like a released bus
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_sync_q <= 3'h7;
      sda_sync_q <= 3'h7;
    end else begin
      scl_sync_q <= {scl_sync_q[1:0], scl_in};
      sda_sync_q <= {sda_sync_q[1:0], sda_in};
    end
  end

  // Register read view; reserved bit and unmapped addresses read zero
  always_comb begin
    rd_byte = 8'h00;
    case (ptr_q)
      OFS_MULT_HI: rd_byte = {mult_q[8], fact_hi_q, fact_lo_q, refdiv_q};
      OFS_MULT_LO: rd_byte = mult_q[7:0];
      OFS_SPREAD: rd_byte = {rise_q, fall_q};
      OFS_RATIO: rd_byte = {direct_q, 1'b0, ratio_q, skew_q};
      OFS_PART_ID: rd_byte = PART_ID_CODE;
      default: rd_byte = 8'h00;
    endcase
  end

  // Serial engine next state; shifts on scl rise, drives on scl fall
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shift_d = shift_q;
    tx_d = tx_q;
    ptr_d = ptr_q;
    rw_d = rw_q;
    block_d = block_q;
    first_d = first_q;
    nack_d = nack_q;
    oe_d = oe_q;
    wr_en = 1'b0;
    if (bus_start) begin
      state_d = ST_ADDR;
      cnt_d = 4'h0;
      oe_d = 1'b0;
    end else if (bus_stop) begin
      state_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (scl_rise) begin
      case (state_q)
        ST_ADDR, ST_CMD, ST_WDATA: begin
          shift_d = {shift_q[6:0], sda_sync_q[1]};
          cnt_d = cnt_q + 4'h1;
        end
        ST_RDATA: cnt_d = cnt_q + 4'h1;
        ST_RDATA_ACK: nack_d = sda_sync_q[1];
        default: ;
      endcase
    end else if (scl_fall) begin
      case (state_q)
        ST_ADDR: begin
          if (cnt_q == 4'h8) begin
            if (shift_q[7:1] == DEV_ADDR) begin
              state_d = ST_ADDR_ACK;
              rw_d = shift_q[0];
              oe_d = 1'b1;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        ST_CMD: begin
          if (cnt_q == 4'h8) begin
            state_d = ST_CMD_ACK;
            ptr_d = shift_q;
            block_d = (shift_q == BLOCK_CMD);
            first_d = 1'b1;
            oe_d = 1'b1;
          end
        end
        ST_WDATA: begin
          if (cnt_q == 4'h8) begin
            // Block count byte is swallowed, other bytes land at the pointer
            state_d = ST_WDATA_ACK;
            oe_d = 1'b1;
            if (block_q && first_q) begin
              first_d = 1'b0;
            end else begin
              wr_en = 1'b1;
              ptr_d = ptr_q + 8'h01;
            end
          end
        end
        ST_CMD_ACK, ST_WDATA_ACK: begin
          state_d = ST_WDATA;
          cnt_d = 4'h0;
          oe_d = 1'b0;
        end
        ST_RDATA: begin
          if (cnt_q == 4'h8) begin
            state_d = ST_RDATA_ACK;
            oe_d = 1'b0;
          end else begin
            tx_d = {tx_q[6:0], 1'b0};
            oe_d = ~tx_d[7];
          end
        end
        ST_ADDR_ACK, ST_RDATA_ACK: begin
          if (state_q == ST_ADDR_ACK && !rw_q) begin
            state_d = ST_CMD;
            cnt_d = 4'h0;
            oe_d = 1'b0;
          end else if (state_q == ST_RDATA_ACK && nack_q) begin
            state_d = ST_IDLE;
            oe_d = 1'b0;
          end else begin
            // Load the next byte and put its msb on the wire
            state_d = ST_RDATA;
            cnt_d = 4'h0;
            if (block_q && first_q) begin
              tx_d = BLOCK_COUNT;
              first_d = 1'b0;
            end else begin
              tx_d = rd_byte;
              ptr_d = ptr_q + 8'h01;
            end
            oe_d = ~tx_d[7];
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
      cnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ptr_q <= 8'h00;
      rw_q <= 1'b0;
      block_q <= 1'b0;
      first_q <= 1'b0;
      nack_q <= 1'b0;
      oe_q <= 1'b0;
      sda_o_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shift_q <= shift_d;
      tx_q <= tx_d;
      ptr_q <= ptr_d;
      rw_q <= rw_d;
      block_q <= block_d;
      first_q <= first_d;
      nack_q <= nack_d;
      oe_q <= oe_d;
      sda_o_q <= 1'b0;
    end
  end

  // Register writes, watchdog fallback and derived outputs
  always_comb begin
    mult_d = mult_q;
    refdiv_d = refdiv_q;
    fact_hi_d = fact_hi_q;
    fact_lo_d = fact_lo_q;
    rise_d = rise_q;
    fall_d = fall_q;
    direct_d = direct_q;
    ratio_d = ratio_q;
    skew_d = skew_q;
    freq_code_d = freq_code_q;
    if (wr_en) begin
      case (ptr_q)
        OFS_MULT_HI: begin
          mult_d[8] = shift_q[BIT_N_MSB];
          fact_hi_d = shift_q[BIT_FACT_HI];
          fact_lo_d = shift_q[BIT_FACT_LO];
          refdiv_d = shift_q[4:0];
        end
        OFS_MULT_LO: mult_d[7:0] = shift_q;
        OFS_SPREAD: begin
          rise_d = shift_q[7:4];
          fall_d = shift_q[3:0];
        end
        OFS_RATIO: begin
          direct_d = shift_q[BIT_DIRECT];
          if (shift_q[5:3] != RATIO_RESERVED) begin
            ratio_d = shift_q[5:3];
          end
          skew_d = shift_q[2:0];
        end
        OFS_PART_ID: ;
        default: ;
      endcase
    end
    // expiry beats a host write of the select bit
    if (watchdog_expire) begin
      direct_d = 1'b0;
      freq_code_d = safe_freq_enable ? fallback_frequency_code : latched_default_code;
    end
    num_d = {1'b0, mult_d} + MULT_OFFSET;
    div_d = pcr_ratio(ratio_d);
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mult_q <= RST_MULT;
      refdiv_q <= RST_REFDIV;
      fact_hi_q <= RST_FACT_HI;
      fact_lo_q <= RST_FACT_LO;
      rise_q <= RST_RISE;
      fall_q <= RST_FALL;
      direct_q <= RST_DIRECT;
      ratio_q <= RST_RATIO;
      skew_q <= RST_SKEW;
      freq_code_q <= RST_FREQ_CODE;
      num_q <= {1'b0, RST_MULT} + MULT_OFFSET;
      div_q <= pcr_ratio(RST_RATIO);
    end else begin
      mult_q <= mult_d;
      refdiv_q <= refdiv_d;
      fact_hi_q <= fact_hi_d;
      fact_lo_q <= fact_lo_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      direct_q <= direct_d;
      ratio_q <= ratio_d;
      skew_q <= skew_d;
      freq_code_q <= freq_code_d;
      num_q <= num_d;
      div_q <= div_d;
    end
  end

  // Outputs straight from flops
  assign sda_out = sda_o_q;
  assign sda_oe = oe_q;
  assign direct_program_select = direct_q;
  assign frequency_select_code = freq_code_q;
  assign vco_numerator = num_q;
  assign vco_denominator = refdiv_q;
  assign spread_rise_count = rise_q;
  assign spread_fall_count = fall_q;
  assign cpu_ratio = div_q[11:8];
  assign v66_ratio = div_q[7:4];
  assign pci_ratio = div_q[3:0];
endmodule : pcr_top
`default_nettype wire

// >>> verilog/pcr_pkg.sv
`default_nettype none
package pcr_pkg;
  // Register byte addresses on the serial bus
  localparam logic [7:0] OFS_MULT_HI = 8'h07;
  localparam logic [7:0] OFS_MULT_LO = 8'h08;
  localparam logic [7:0] OFS_SPREAD = 8'h09;
  localparam logic [7:0] OFS_RATIO = 8'h0a;
  localparam logic [7:0] OFS_PART_ID = 8'h0b;
  // Serial bus target address 0xd2, kept as its 7-bit form
  localparam logic [6:0] DEV_ADDR = 7'h69;
  // Command code that selects block mode, and the byte count a block read returns
  localparam logic [7:0] BLOCK_CMD = 8'h00;
  localparam logic [7:0] BLOCK_COUNT = 8'h0c;
  // Field positions
  localparam int BIT_N_MSB = 7;
  localparam int BIT_FACT_HI = 6;
  localparam int BIT_FACT_LO = 5;
  localparam int BIT_DIRECT = 7;
  // Values after reset
  localparam logic RST_FACT_HI = 1'b1;
  localparam logic RST_FACT_LO = 1'b0;
  localparam logic [8:0] RST_MULT = 9'h000;
  localparam logic [4:0] RST_REFDIV = 5'h00;
  localparam logic [3:0] RST_RISE = 4'h1;
  localparam logic [3:0] RST_FALL = 4'hf;
  localparam logic RST_DIRECT = 1'b0;
  localparam logic [2:0] RST_RATIO = 3'h0;
  localparam logic [2:0] RST_SKEW = 3'h4;
  localparam logic [4:0] RST_FREQ_CODE = 5'h00;
  // Ratio code with undefined outputs
  localparam logic [2:0] RATIO_RESERVED = 3'h7;
  // Offset added to the multiplier, and the reference rate in kHz
  localparam logic [9:0] MULT_OFFSET = 10'h004;
  localparam int REF_CLOCK_KHZ = 14318;
  // Part identifier; this value is arbitrary
  localparam logic [7:0] PART_ID_CODE = 8'h5a;
  // Serial engine states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
    ST_WDATA, ST_WDATA_ACK, ST_RDATA, ST_RDATA_ACK
  } pcr_state_e;
  // Divide ratios {cpu, 3v66, pci} for a ratio code
  function automatic logic [11:0] pcr_ratio(input logic [2:0] sel);
    case (sel)
      3'h0: pcr_ratio = {4'h2, 4'h4, 4'h8};
      3'h1: pcr_ratio = {4'h2, 4'h5, 4'ha};
      3'h2: pcr_ratio = {4'h2, 4'h6, 4'hc};
      3'h3: pcr_ratio = {4'h3, 4'h6, 4'hc};
      3'h4: pcr_ratio = {4'h4, 4'h4, 4'h8};
      3'h5: pcr_ratio = {4'h4, 4'h6, 4'hc};
      3'h6: pcr_ratio = {4'h6, 4'h6, 4'hc};
      default: pcr_ratio = {4'h2, 4'h4, 4'h8};
    endcase
  endfunction : pcr_ratio
endpackage : pcr_pkg
`default_nettype wire

// >>> verification/pcr_assertions.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the programming outputs against the watchdog inputs and bus pins
module pcr_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic srst,
  // Bus pins driven by the block
  input wire logic sda_out,
  input wire logic sda_oe,
  // Watchdog inputs
  input wire logic watchdog_expire,
  input wire logic safe_freq_enable,
  input wire logic [4:0] fallback_frequency_code,
  input wire logic [4:0] latched_default_code,
  // Programming outputs
  input wire logic direct_program_select,
  input wire logic [4:0] frequency_select_code,
  input wire logic [9:0] vco_numerator,
  input wire logic [3:0] spread_rise_count,
  input wire logic [3:0] spread_fall_count,
  input wire logic [3:0] cpu_ratio,
  input wire logic [3:0] v66_ratio,
  input wire logic [3:0] pci_ratio
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // Three ratios seen as one value
  wire logic [11:0] ratios = {cpu_ratio, v66_ratio, pci_ratio};
  // Expiry with reload on, and with reload off
  sequence s_reload; watchdog_expire && safe_freq_enable; endsequence
  sequence s_default; watchdog_expire && !safe_freq_enable; endsequence
  property p_wd_clear; watchdog_expire |=> !direct_program_select; endproperty
  property p_wd_reload; s_reload |=> frequency_select_code == $past(fallback_frequency_code);
  endproperty
  property p_wd_default; s_default |=> frequency_select_code == $past(latched_default_code);
  endproperty
  // The code moves only on expiry; the edge after reset is excused
  property p_fsc_hold;
    !$stable(frequency_select_code) && !$past(srst) |-> $past(watchdog_expire);
  endproperty
  property p_reset_vals; $fell(srst) |-> {spread_rise_count, spread_fall_count} == 8'h1f
    && ratios == 12'h248 && vco_numerator == 10'h004 && !direct_program_select; endproperty
  property p_ratio_legal; ratios inside {12'h248, 12'h25a, 12'h26c, 12'h36c, 12'h448,
    12'h46c, 12'h66c}; endproperty
  // Nine-bit value plus four never leaves this span
  property p_num_range; vco_numerator inside {[10'd4:10'd515]}; endproperty
  property p_ack_hold; $rose(sda_oe) |=> sda_oe [*8]; endproperty
  property p_sda_low; sda_out == 1'b0; endproperty
  a_wd_clear: assert property (p_wd_clear) else $error("select survived expiry");
  a_wd_reload: assert property (p_wd_reload) else $error("fallback not loaded");
  a_wd_default: assert property (p_wd_default) else $error("default not loaded");
  a_fsc_hold: assert property (p_fsc_hold) else $error("code moved unprompted");
  a_reset_vals: assert property (p_reset_vals) else $error("bad reset outputs");
  a_ratio_legal: assert property (p_ratio_legal) else $error("ratio triple illegal");
  a_num_range: assert property (p_num_range) else $error("numerator off range");
  a_ack_hold: assert property (p_ack_hold) else $error("bus drive too short");
  a_sda_low: assert property (p_sda_low) else $error("data pin not open drain");
endmodule : pcr_checker
bind pcr_top pcr_checker pcr_checker_inst (.clk(clk), .srst(srst), .sda_out(sda_out),
  .sda_oe(sda_oe), .watchdog_expire(watchdog_expire), .safe_freq_enable(safe_freq_enable),
  .fallback_frequency_code(fallback_frequency_code),
  .latched_default_code(latched_default_code),
  .direct_program_select(direct_program_select),
  .frequency_select_code(frequency_select_code), .vco_numerator(vco_numerator),
  .spread_rise_count(spread_rise_count), .spread_fall_count(spread_fall_count),
  .cpu_ratio(cpu_ratio), .v66_ratio(v66_ratio), .pci_ratio(pci_ratio));
`default_nettype wire

// >>> verification/pcr_host.sv
`timescale 1ns/1ps
`default_nettype none
// Bus host; paced off falling clock edges with margins above the four-clock minimum
module pcr_host (
  // Clock
  input wire logic clk,
  // Bus lines
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  // Idle bus: both lines released
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hp(input int n);
    repeat (n) @(negedge clk);
  endtask : hp
  // One bit; data changes only while the clock line is low
  task automatic bit_x(input logic b, output logic r);
    sda_low = !b;
    hp(5);
    scl = 1'b1;
    hp(6);
    r = sda_line;
    scl = 1'b0;
    hp(5);
  endtask : bit_x
  // Start, or repeated start when the clock line is low
  task automatic start();
    if (!scl) begin
      sda_low = 1'b0;
      hp(5);
      scl = 1'b1;
      hp(6);
    end
    sda_low = 1'b1;
    hp(6);
    scl = 1'b0;
    hp(5);
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    hp(5);
    scl = 1'b1;
    hp(6);
    sda_low = 1'b0;
    hp(6);
  endtask : stop
  // Byte out MSB first, then the ninth bit released; k is low on acknowledge
  task automatic xbyte(input logic [7:0] d, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) bit_x(d[i], r[i]);
    bit_x(1'b1, k);
  endtask : xbyte
  // Address byte alone, to probe for acknowledge
  task automatic probe(input logic [7:0] b, output logic k);
    logic [7:0] r;
    start();
    xbyte(b, r, k);
    stop();
  endtask : probe
  task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] r;
    logic k0, k1, k2;
    start();
    xbyte(8'hd2, r, k0);
    xbyte(a, r, k1);
    xbyte(d, r, k2);
    stop();
    ok = !(k0 | k1 | k2);
  endtask : wr
  // Byte read; the trailing released bit is the host's no-acknowledge
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic k0, k1, k2, kn;
    start();
    xbyte(8'hd2, d, k0);
    xbyte(a, d, k1);
    start();
    xbyte(8'hd3, d, k2);
    xbyte(8'hff, d, kn);
    stop();
    ok = !(k0 | k1 | k2);
  endtask : rd
  // Block read: count byte acknowledged, first register byte refused
  task automatic blk_rd(output logic [7:0] c, output logic [7:0] d0, output logic ok);
    logic [7:0] r;
    logic k0, k1, k2, ka;
    start();
    xbyte(8'hd2, r, k0);
    xbyte(8'h00, r, k1);
    start();
    xbyte(8'hd3, r, k2);
    for (int i = 7; i >= 0; i--) bit_x(1'b1, c[i]);
    bit_x(1'b0, ka);
    xbyte(8'hff, d0, ka);
    stop();
    ok = !(k0 | k1 | k2);
  endtask : blk_rd
endmodule : pcr_host
`default_nettype wire

// >>> verification/pcr_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module pcr_top_tb;
  import pcr_pkg::*;
  // Stimulus and observed signals
  logic clk, srst, we, sfe, scl, host_low, sda_out, sda_oe, dps;
  logic [4:0] fb, ld, fsc, den;
  logic [9:0] num;
  logic [3:0] rise, fall, cpu, v66, pci;
  int fail_count, n_tests;
  logic ok;
  // Pulled-up data wire, low while either side pulls
  wire logic sda = !((sda_oe & !sda_out) | host_low);
  pcr_top pcr_top_inst (.clk(clk), .srst(srst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .watchdog_expire(we), .safe_freq_enable(sfe),
    .fallback_frequency_code(fb), .latched_default_code(ld), .direct_program_select(dps),
    .frequency_select_code(fsc), .vco_numerator(num), .vco_denominator(den),
    .spread_rise_count(rise), .spread_fall_count(fall), .cpu_ratio(cpu),
    .v66_ratio(v66), .pci_ratio(pci));
  pcr_host pcr_host_inst (.clk(clk), .sda_line(sda), .scl(scl), .sda_low(host_low));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    pcr_host_inst.wr(a, d, ok);
    chk("write ack", 16'h1, {15'h0, ok});
  endtask : w
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    pcr_host_inst.rd(a, d, ok);
    chk("read ack", 16'h1, {15'h0, ok});
    chk("read data", {8'h0, exp}, {8'h0, d});
  endtask : rchk
  // Reset contents of all five registers and the vco and spread outputs
  task automatic t_reset();
    logic [7:0] rv [5] = '{8'h40, 8'h00, 8'h1f, 8'h04, PART_ID_CODE};
    for (int i = 0; i < 5; i++) rchk(OFS_MULT_HI + 8'(i), rv[i]);
    chk("vco", 16'h0080, {1'b0, num, den});
    chk("spread", 16'h001f, {8'h0, rise, fall});
  endtask : t_reset
  // Top multiplier bit, factory bits kept, divider at an odd value
  task automatic t_mult();
    w(OFS_MULT_HI, 8'hd3);
    w(OFS_MULT_LO, 8'hff);
    chk("vco", {1'b0, 10'h203, 5'h13}, {1'b0, num, den});
    rchk(OFS_MULT_HI, 8'hd3);
  endtask : t_mult
  // Every ratio code, then the reserved one with direct mode off
  task automatic t_ratio();
    logic [11:0] tbl [7] = '{12'h248, 12'h25a, 12'h26c, 12'h36c, 12'h448, 12'h46c, 12'h66c};
    for (int i = 0; i < 7; i++) begin
      w(OFS_RATIO, {2'b10, 3'(i), 3'h4});
      chk("ratios", {4'h0, tbl[i]}, {4'h0, cpu, v66, pci});
    end
    chk("select", 16'h1, {15'h0, dps});
    w(OFS_RATIO, 8'h3c);
    chk("ratios kept", {4'h0, 12'h66c}, {4'h0, cpu, v66, pci});
    chk("select off", 16'h0, {15'h0, dps});
  endtask : t_ratio
  task automatic t_spread();
    w(OFS_SPREAD, 8'ha5);
    chk("spread", 16'h00a5, {8'h0, rise, fall});
  endtask : t_spread
  // Read-only identifier, unmapped place, foreign address
  task automatic t_ro();
    logic k;
    w(OFS_PART_ID, 8'h00);
    rchk(OFS_PART_ID, PART_ID_CODE);
    rchk(8'h20, 8'h00);
    pcr_host_inst.probe(8'ha4, k);
    chk("foreign nack", 16'h1, {15'h0, k});
  endtask : t_ro
  // Block mode: count byte first, then register zero, which is unmapped
  task automatic t_block();
    logic [7:0] c, d0;
    pcr_host_inst.blk_rd(c, d0, ok);
    chk("block ack", 16'h1, {15'h0, ok});
    chk("block count", {8'h0, BLOCK_COUNT}, {8'h0, c});
    chk("block byte0", 16'h0, {8'h0, d0});
  endtask : t_block
  // Reset in mid-run brings the outputs and registers back to reset values
  task automatic t_rst_mid();
    srst = 1'b1;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    repeat (3) @(negedge clk);
    chk("spread after reset", 16'h001f, {8'h0, rise, fall});
    chk("ratios after reset", 16'h0248, {4'h0, cpu, v66, pci});
    chk("code after reset", 16'h0, {10'h0, dps, fsc});
    rchk(OFS_MULT_HI, 8'h40);
  endtask : t_rst_mid
  // Expiry with reload on, then off
  task automatic t_wdog();
    for (int i = 1; i >= 0; i--) begin
      w(OFS_RATIO, 8'h84);
      chk("select set", 16'h1, {15'h0, dps});
      sfe = i[0];
      @(negedge clk);
      we = 1'b1;
      @(negedge clk);
      we = 1'b0;
      chk("expiry", {10'h0, 1'b0, i ? 5'h15 : 5'h0a}, {10'h0, dps, fsc});
    end
  endtask : t_wdog
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  // Main sequence: reset three cycles, then the scenarios
  initial begin
    srst = 1'b1;
    we = 1'b0;
    sfe = 1'b0;
    fb = 5'h15;
    ld = 5'h0a;
    repeat (3) @(negedge clk);
    srst = 1'b0;
    repeat (3) @(negedge clk);
    t_reset();
    t_mult();
    t_ratio();
    t_spread();
    t_ro();
    t_block();
    t_wdog();
    t_rst_mid();
    wrap_up();
  end
  // Hang guard, nearly five times the expected run
  initial begin
    #3000000;
    fail_count++;
    wrap_up();
  end
endmodule : pcr_top_tb
`default_nettype wire
